// file: shared/lcdd_pkg.sv
// constants and types of the segment display driver control
// Summary of operation
// - The display is driven only while the enable bit of the control port is one; zero means off.
// - Control bits 2..0 pick the scheme: 000 quarter/third bias, 001 quarter/half bias, 010 third duty/third bias, 011 third duty/half bias, 100 half duty/half bias, 101 static, 11x reserved.
// - Segment data is fetched from data RAM starting at address 20H.
// - Segment line n takes its nibble from RAM address 20H plus n, up to 3FH, and nibble bit k steers common line k.
// - Quarter duty uses bits 0..3, third duty bits 0..2, half duty bits 0..1, static bit 0 only; other bits are ignored.
// - Frame rate is 64 Hz at quarter duty, 85 Hz at third duty, 128 Hz at half duty and 64 Hz static.
// - Reset clears the control port to zero: display off, quarter duty with third bias.
// - While disabled every common and segment output sits at the negative supply level.
// - The driver is forced off during reset and during stop mode, whatever the enable bit says.
package lcdd_pkg;
    localparam logic [4:0] CTRL_OFFSET = 5'h1B;
    localparam int EN_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] RAM_BASE = 8'h20;
    localparam logic [4:0] SEG_LAST = 5'h1F;
    localparam int SEG_COUNT = 32;
    localparam int CNT_W = 24;
    localparam longint CLK_HZ = 100_000_000;
    localparam longint FRAME_HZ_QUARTER = 64;
    localparam longint FRAME_HZ_THIRD = 85;
    localparam longint FRAME_HZ_HALF = 128;
    localparam longint FRAME_HZ_STATIC = 64;
    localparam logic [2:0] SCH_Q_THIRD = 3'h0;
    localparam logic [2:0] SCH_Q_HALF = 3'h1;
    localparam logic [2:0] SCH_T_THIRD = 3'h2;
    localparam logic [2:0] SCH_T_HALF = 3'h3;
    localparam logic [2:0] SCH_H_HALF = 3'h4;
    localparam logic [2:0] SCH_STATIC = 3'h5;
    // drive level codes handed to the analog bias switches
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;

    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } lcdd_state_t;

    function automatic logic lcdd_reserved(input logic [2:0] sch);
        return sch[2] & sch[1];
    endfunction : lcdd_reserved

    function automatic logic [2:0] lcdd_slots(input logic [2:0] sch);
        case (sch)
            SCH_Q_THIRD, SCH_Q_HALF: return 3'h4;
            SCH_T_THIRD, SCH_T_HALF: return 3'h3;
            SCH_H_HALF: return 3'h2;
            default: return 3'h1;
        endcase
    endfunction : lcdd_slots

    function automatic logic lcdd_third_bias(input logic [2:0] sch);
        return (sch == SCH_Q_THIRD) || (sch == SCH_T_THIRD);
    endfunction : lcdd_third_bias
endpackage : lcdd_pkg

// file: shared/lcdd_fetch_if.sv
// carries the fetched display nibbles from the RAM walker to the control core
`timescale 1ns/1ps
interface lcdd_fetch_if;
    logic start;
    logic wr;
    logic [4:0] idx;
    logic [3:0] nib;
    modport core (output start, input wr, input idx, input nib);
    modport walker (input start, output wr, output idx, output nib);
endinterface : lcdd_fetch_if

// file: design/lcdd_fetch.sv
// walks the display area of data RAM and returns one nibble per segment line
`timescale 1ns/1ps
module lcdd_fetch (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    lcdd_fetch_if.walker fif,
    output logic ram_re,
    output logic [7:0] ram_addr,
    input wire logic [3:0] ram_rdata
);
    typedef struct packed {
        logic busy;
        logic [4:0] idx;
        logic re;
        logic [7:0] addr;
        logic pend;
        logic [4:0] pidx;
    } lcdd_fetch_st_t;

    lcdd_fetch_st_t st;
    lcdd_fetch_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.re = 1'b0;
        // RAM answers one cycle after it sees the read strobe
        next_st.pend = st.re;
        next_st.pidx = st.addr[4:0];
        if (st.busy) begin
            next_st.re = 1'b1;
            next_st.addr = lcdd_pkg::RAM_BASE + {3'h0, st.idx};
            next_st.idx = st.idx + 5'h1;
            if (st.idx == lcdd_pkg::SEG_LAST) begin
                next_st.busy = 1'b0;
            end
        end
        if (fif.start) begin
            next_st.busy = 1'b1;
            next_st.idx = 5'h0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign ram_re = st.re;
    assign ram_addr = st.addr;
    assign fif.wr = st.pend;
    assign fif.idx = st.pidx;
    assign fif.nib = ram_rdata;

    AST_FETCH_ADDR: assert property (@(posedge clock) disable iff (!rstn)
        ram_re |-> (ram_addr >= 8'h20 && ram_addr <= 8'h3F))
        else $error("display fetch outside the display area");

    AST_FETCH_RETURN: assert property (@(posedge clock) disable iff (!rstn)
        (ram_re && ce) |=> (fif.wr && fif.idx == $past(ram_addr[4:0])))
        else $error("fetched nibble not returned with its index");
endmodule : lcdd_fetch

// file: design/lcdd_top.sv
// control, scan timing and level selection of the segment display driver
`timescale 1ns/1ps
module lcdd_top #(
    parameter int unsigned SLOT_CYC_QUARTER =
        int'(lcdd_pkg::CLK_HZ / (lcdd_pkg::FRAME_HZ_QUARTER * 4)),
    parameter int unsigned SLOT_CYC_THIRD =
        int'(lcdd_pkg::CLK_HZ / (lcdd_pkg::FRAME_HZ_THIRD * 3)),
    parameter int unsigned SLOT_CYC_HALF =
        int'(lcdd_pkg::CLK_HZ / (lcdd_pkg::FRAME_HZ_HALF * 2)),
    parameter int unsigned SLOT_CYC_STATIC =
        int'(lcdd_pkg::CLK_HZ / lcdd_pkg::FRAME_HZ_STATIC)
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic PORT_WE,
    input wire logic [4:0] PORT_ADDR,
    input wire logic [3:0] PORT_DATA,
    input wire logic STOP_MODE,
    output logic RAM_RE,
    output logic [7:0] RAM_ADDR,
    input wire logic [3:0] RAM_RDATA,
    output logic [7:0] COM_LEVEL,
    output logic [63:0] SEG_LEVEL,
    output logic DISPLAY_ACTIVE,
    output logic BIAS_HALF
);
    typedef struct packed {
        logic on;
        logic [2:0] scheme;
        lcdd_pkg::lcdd_state_t state;
        logic [1:0] slot;
        logic pol;
        logic [lcdd_pkg::CNT_W-1:0] cnt;
        logic [31:0][3:0] nib;
        logic [7:0] com;
        logic [63:0] seg;
    } lcdd_top_st_t;

    lcdd_top_st_t st;
    lcdd_top_st_t next_st;
    logic wr_ok;
    logic fetch_start;

    lcdd_fetch_if fif ();

    lcdd_fetch u_fetch (
        .clock(CLOCK),
        .rstn(RSTN),
        .ce(CE),
        .fif(fif.walker),
        .ram_re(RAM_RE),
        .ram_addr(RAM_ADDR),
        .ram_rdata(RAM_RDATA)
    );

    // reload value of the slot counter, one less than the slot length
    function automatic logic [lcdd_pkg::CNT_W-1:0] slot_reload(input logic [2:0] sch);
        case (lcdd_pkg::lcdd_slots(sch))
            3'h4: return lcdd_pkg::CNT_W'(SLOT_CYC_QUARTER - 1);
            3'h3: return lcdd_pkg::CNT_W'(SLOT_CYC_THIRD - 1);
            3'h2: return lcdd_pkg::CNT_W'(SLOT_CYC_HALF - 1);
            default: return lcdd_pkg::CNT_W'(SLOT_CYC_STATIC - 1);
        endcase
    endfunction : slot_reload

    always_comb begin
        next_st = st;
        fetch_start = 1'b0;
        wr_ok = PORT_WE && (PORT_ADDR == lcdd_pkg::CTRL_OFFSET);
        if (wr_ok) begin
            next_st.on = PORT_DATA[lcdd_pkg::EN_BIT];
            // reserved codes leave the running scheme untouched
            if (!lcdd_pkg::lcdd_reserved(PORT_DATA[2:0])) begin
                next_st.scheme = PORT_DATA[2:0];
            end
        end
        if (fif.wr) begin
            next_st.nib[fif.idx] = fif.nib;
        end
        case (st.state)
            lcdd_pkg::ST_OFF: begin
                if (next_st.on && !STOP_MODE) begin
                    next_st.state = lcdd_pkg::ST_RUN;
                    next_st.slot = 2'h0;
                    next_st.pol = 1'b0;
                    next_st.cnt = slot_reload(next_st.scheme);
                    fetch_start = 1'b1;
                end
            end
            lcdd_pkg::ST_RUN: begin
                if (!next_st.on || STOP_MODE) begin
                    next_st.state = lcdd_pkg::ST_OFF;
                end else if (wr_ok) begin
                    // a new scheme restarts the frame so slots never exceed the duty
                    next_st.slot = 2'h0;
                    next_st.pol = 1'b0;
                    next_st.cnt = slot_reload(next_st.scheme);
                    fetch_start = 1'b1;
                end else if (st.cnt == '0) begin
                    next_st.cnt = slot_reload(st.scheme);
                    if ({1'b0, st.slot} == lcdd_pkg::lcdd_slots(st.scheme) - 3'h1) begin
                        // frame end: flip polarity so the glass sees no net DC
                        next_st.slot = 2'h0;
                        next_st.pol = ~st.pol;
                        fetch_start = 1'b1;
                    end else begin
                        next_st.slot = st.slot + 2'h1;
                    end
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            default: begin
                next_st.state = lcdd_pkg::ST_OFF;
            end
        endcase
        for (int k = 0; k < 4; k++) begin
            if (next_st.state != lcdd_pkg::ST_RUN) begin
                next_st.com[2*k +: 2] = lcdd_pkg::LVL_VSS;
            end else if (3'(k) >= lcdd_pkg::lcdd_slots(next_st.scheme)) begin
                next_st.com[2*k +: 2] = lcdd_pkg::LVL_VSS;
            end else if (2'(k) == next_st.slot) begin
                next_st.com[2*k +: 2] = next_st.pol ? lcdd_pkg::LVL_V3 : lcdd_pkg::LVL_VSS;
            end else if (lcdd_pkg::lcdd_third_bias(next_st.scheme)) begin
                next_st.com[2*k +: 2] = next_st.pol ? lcdd_pkg::LVL_V1 : lcdd_pkg::LVL_V2;
            end else begin
                next_st.com[2*k +: 2] = lcdd_pkg::LVL_V1;
            end
        end
        for (int s = 0; s < lcdd_pkg::SEG_COUNT; s++) begin
            if (next_st.state != lcdd_pkg::ST_RUN) begin
                next_st.seg[2*s +: 2] = lcdd_pkg::LVL_VSS;
            end else if (next_st.nib[s][next_st.slot]) begin
                // only the bit of the active slot is read, unused bits never matter
                next_st.seg[2*s +: 2] = next_st.pol ? lcdd_pkg::LVL_VSS : lcdd_pkg::LVL_V3;
            end else if (lcdd_pkg::lcdd_third_bias(next_st.scheme)) begin
                next_st.seg[2*s +: 2] = next_st.pol ? lcdd_pkg::LVL_V2 : lcdd_pkg::LVL_V1;
            end else begin
                next_st.seg[2*s +: 2] = next_st.pol ? lcdd_pkg::LVL_V3 : lcdd_pkg::LVL_VSS;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '0;
            st.on <= lcdd_pkg::CTRL_RESET[lcdd_pkg::EN_BIT];
            st.scheme <= lcdd_pkg::CTRL_RESET[2:0];
            st.state <= lcdd_pkg::ST_OFF;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign fif.start = fetch_start && CE;
    assign COM_LEVEL = st.com;
    assign SEG_LEVEL = st.seg;
    assign DISPLAY_ACTIVE = (st.state == lcdd_pkg::ST_RUN);
    assign BIAS_HALF = !lcdd_pkg::lcdd_third_bias(st.scheme);

    AST_OFF_VSS: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (st.state == lcdd_pkg::ST_OFF) |-> (COM_LEVEL == 8'h00 && SEG_LEVEL == 64'h0))
        else $error("outputs not at negative supply while off");

    AST_STOP_OFF: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (STOP_MODE && CE) |=> !DISPLAY_ACTIVE)
        else $error("driver active during stop mode");

    AST_WRITE_CTRL: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && PORT_WE && PORT_ADDR == 5'h1B && !(PORT_DATA[2] && PORT_DATA[1]))
        |=> (st.on == $past(PORT_DATA[3]) && st.scheme == $past(PORT_DATA[2:0])))
        else $error("control write not taken");

    AST_ENABLE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && PORT_WE && PORT_ADDR == 5'h1B && PORT_DATA[3] && !STOP_MODE)
        |=> DISPLAY_ACTIVE)
        else $error("display not started by enable write");

    AST_RESV_KEEP: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (PORT_WE && PORT_ADDR == 5'h1B && PORT_DATA[2] && PORT_DATA[1])
        |=> st.scheme == $past(st.scheme))
        else $error("reserved scheme code taken");

    AST_SLOT_RANGE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        DISPLAY_ACTIVE |-> ({1'b0, st.slot} < lcdd_pkg::lcdd_slots(st.scheme)))
        else $error("slot beyond the selected duty");

    AST_COM_SEL: assert property (@(posedge CLOCK) disable iff (!RSTN)
        DISPLAY_ACTIVE |-> (COM_LEVEL[2*st.slot +: 2] == (st.pol ? 2'h3 : 2'h0)))
        else $error("active common line not at select level");

    AST_RELOAD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && DISPLAY_ACTIVE && st.cnt == '0 && !PORT_WE && !STOP_MODE)
        |=> (st.cnt == slot_reload(st.scheme) && st.slot != $past(st.slot)
             || lcdd_pkg::lcdd_slots(st.scheme) == 3'h1))
        else $error("slot counter not reloaded at slot end");

    // the bias flag feeds the analog switches, so it must follow every accepted code
    AST_BIAS_SEL: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && PORT_WE && PORT_ADDR == 5'h1B
         && PORT_DATA[2:0] inside {3'h1, 3'h3, 3'h4, 3'h5})
        |=> BIAS_HALF)
        else $error("half bias not selected by scheme write");

    AST_BIAS_THIRD: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && PORT_WE && PORT_ADDR == 5'h1B && PORT_DATA[2:0] inside {3'h0, 3'h2})
        |=> !BIAS_HALF)
        else $error("third bias not selected by scheme write");

    // commons beyond the selected duty stay at the negative supply
    AST_COM_UNUSED: assert property (@(posedge CLOCK) disable iff (!RSTN)
        DISPLAY_ACTIVE |->
        ((lcdd_pkg::lcdd_slots(st.scheme) > 3'h3 || COM_LEVEL[7:6] == 2'h0)
         && (lcdd_pkg::lcdd_slots(st.scheme) > 3'h2 || COM_LEVEL[5:4] == 2'h0)
         && (lcdd_pkg::lcdd_slots(st.scheme) > 3'h1 || COM_LEVEL[3:2] == 2'h0)))
        else $error("unused common line driven");

    // a display start must walk the area from its base, never resume a stale walk
    AST_FETCH_BASE: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ($rose(DISPLAY_ACTIVE) && CE) |=> (RAM_RE && RAM_ADDR == 8'h20))
        else $error("display start did not fetch from the area base");

    AST_SLOT_COUNT: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && DISPLAY_ACTIVE && st.cnt != '0 && !PORT_WE && !STOP_MODE)
        |=> (st.cnt == $past(st.cnt) - 1'b1 && st.slot == $past(st.slot)))
        else $error("slot counter did not step down");

    // polarity must turn over, and the slots restart at 0, after the last used slot of a frame
    AST_FRAME_FLIP: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CE && DISPLAY_ACTIVE && st.cnt == '0 && !PORT_WE && !STOP_MODE
         && {1'b0, st.slot} == lcdd_pkg::lcdd_slots(st.scheme) - 3'h1)
        |=> (st.slot == 2'h0 && st.pol != $past(st.pol)))
        else $error("frame end did not restart the slots with flipped polarity");
endmodule : lcdd_top

// file: sim/lcdd_ram_model.sv
// synchronous display ram model that also checks the fetch address order
`timescale 1ns/1ps
module lcdd_ram_model (
    input wire logic clock,
    input wire logic re,
    input wire logic [7:0] addr,
    output logic [3:0] rdata,
    output int errs
);
    logic [3:0] mem [32];
    logic [7:0] next_addr;
    initial begin
        errs = 0;
        next_addr = 8'h20;
        rdata = 4'h5;
    end
    always @(posedge clock) begin
        if (re) begin
            // a restart from the area base is legal at any time
            if (addr[7:5] !== 3'h1 || (addr !== next_addr && addr !== 8'h20)) begin
                errs <= errs + 1;
            end
            next_addr <= (addr == 8'h3F) ? 8'h20 : addr + 8'h01;
            rdata <= mem[addr[4:0]];
        end else begin
            // data is only valid the cycle after a read, so scramble it otherwise
            rdata <= ~rdata;
        end
    end
endmodule : lcdd_ram_model

// file: sim/tb_top.sv
// self-checking bench of the segment display driver control
`timescale 1ns/1ps
module tb_top;
    localparam int SQ = 80;
    localparam int ST = 82;
    localparam int SH = 86;
    localparam int SS = 94;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic CE = 1'b1;
    logic PORT_WE = 1'b0;
    logic [4:0] PORT_ADDR = 5'h00;
    logic [3:0] PORT_DATA = 4'h0;
    logic STOP_MODE = 1'b0;
    logic RAM_RE;
    logic [7:0] RAM_ADDR;
    logic [3:0] RAM_RDATA;
    logic [7:0] COM_LEVEL;
    logic [63:0] SEG_LEVEL;
    logic DISPLAY_ACTIVE;
    logic BIAS_HALF;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int ram_errs;
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) cyc <= cyc + 1;
    lcdd_top #(.SLOT_CYC_QUARTER(SQ), .SLOT_CYC_THIRD(ST), .SLOT_CYC_HALF(SH),
        .SLOT_CYC_STATIC(SS)) uut (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .PORT_WE(PORT_WE),
        .PORT_ADDR(PORT_ADDR), .PORT_DATA(PORT_DATA), .STOP_MODE(STOP_MODE), .RAM_RE(RAM_RE),
        .RAM_ADDR(RAM_ADDR), .RAM_RDATA(RAM_RDATA), .COM_LEVEL(COM_LEVEL),
        .SEG_LEVEL(SEG_LEVEL), .DISPLAY_ACTIVE(DISPLAY_ACTIVE), .BIAS_HALF(BIAS_HALF));
    lcdd_ram_model ram (.clock(CLOCK), .re(RAM_RE), .addr(RAM_ADDR), .rdata(RAM_RDATA),
        .errs(ram_errs));
    task automatic chk1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask : chk1
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk64
    task automatic port_wr(input logic [4:0] a, input logic [3:0] d);
        @(negedge CLOCK);
        PORT_WE = 1'b1;
        PORT_ADDR = a;
        PORT_DATA = d;
        @(negedge CLOCK);
        PORT_WE = 1'b0;
    endtask : port_wr
    function automatic int slot_len(input logic [2:0] s);
        return (s < 3'h2) ? SQ : (s < 3'h4) ? ST : (s == 3'h4) ? SH : SS;
    endfunction : slot_len
    function automatic int duty(input logic [2:0] s);
        return (s < 3'h2) ? 4 : (s < 3'h4) ? 3 : (s == 3'h4) ? 2 : 1;
    endfunction : duty
    function automatic logic [7:0] com_exp(input logic [2:0] s, input int k, input logic pol);
        logic [7:0] v;
        v = 8'h00;
        for (int c = 0; c < duty(s); c++) begin
            if (c == k) v[2*c +: 2] = pol ? 2'h3 : 2'h0;
            else v[2*c +: 2] = (s == 3'h0 || s == 3'h2) ? (pol ? 2'h1 : 2'h2) : 2'h1;
        end
        return v;
    endfunction : com_exp
    function automatic logic [63:0] seg_exp(input logic [2:0] s, input int k, input logic pol);
        logic [63:0] v;
        for (int n = 0; n < 32; n++) begin
            if (ram.mem[n][k]) v[2*n +: 2] = pol ? 2'h0 : 2'h3;
            else if (s == 3'h0 || s == 3'h2) v[2*n +: 2] = pol ? 2'h2 : 2'h1;
            else v[2*n +: 2] = pol ? 2'h3 : 2'h0;
        end
        return v;
    endfunction : seg_exp
    // sample late in every slot of one frame, then slot 0 of the next, inverted frame
    task automatic frame(input logic [3:0] wd, input logic [2:0] s);
        int w;
        int sl;
        int nd;
        sl = slot_len(s);
        nd = duty(s);
        port_wr(5'h1B, wd);
        w = cyc;
        chk1(DISPLAY_ACTIVE, 1'b1, "active");
        if (s != 3'h5) chk1(BIAS_HALF, !(s == 3'h0 || s == 3'h2), "bias");
        for (int k = 0; k <= nd; k++) begin
            wait (cyc == w + k * sl + sl - 10);
            @(negedge CLOCK);
            chk64(64'(COM_LEVEL), 64'(com_exp(s, k % nd, k == nd)), "com");
            chk64(SEG_LEVEL, seg_exp(s, k % nd, k == nd), "seg");
        end
    endtask : frame
    task automatic off_chk;
        @(negedge CLOCK);
        chk1(DISPLAY_ACTIVE, 1'b0, "off");
        chk64(64'(COM_LEVEL), 64'h0, "com off");
        chk64(SEG_LEVEL, 64'h0, "seg off");
    endtask : off_chk
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #500000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        void'($urandom(71664));
        repeat (16) @(posedge CLOCK);
        off_chk();
        RSTN = 1'b1;
        off_chk();
        for (int i = 0; i < 6; i++) begin
            for (int n = 0; n < 32; n++) ram.mem[n] = 4'($urandom);
            // stray write to another port must leave the display alone
            port_wr(5'($urandom_range(0, 26)), 4'($urandom));
            frame({1'b1, 3'(i)}, 3'(i));
        end
        frame(4'hA, 3'h2);
        frame(4'hE, 3'h2);
        frame(4'hF, 3'h2);
        port_wr(5'h1B, 4'h0);
        off_chk();
        port_wr(5'h1A, 4'h8);
        off_chk();
        CE = 1'b0;
        port_wr(5'h1B, 4'h8);
        CE = 1'b1;
        off_chk();
        port_wr(5'h1B, 4'h8);
        chk1(DISPLAY_ACTIVE, 1'b1, "on");
        STOP_MODE = 1'b1;
        @(negedge CLOCK);
        off_chk();
        STOP_MODE = 1'b0;
        repeat (5) @(negedge CLOCK);
        chk1(DISPLAY_ACTIVE, 1'b1, "resume");
        RSTN = 1'b0;
        off_chk();
        repeat (2) @(negedge CLOCK);
        RSTN = 1'b1;
        off_chk();
        chk64(64'(ram_errs), 64'h0, "fetch order");
        wrap_up();
    end
endmodule : tb_top
